// ---- bench/sxb_bus_sva.sv ----
// Port checker for the external data bus engine.
// Assumes one clock and a synchronous reset; bound to sxb_bus below.
`timescale 1ns/1ps
module sxb_bus_sva
    import sxb_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire sxb_sfr_req_t sfr,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rvalid,
    input wire logic fetch_start,
    input wire logic [15:0] fetch_addr,
    input wire logic move_start,
    input wire logic ready,
    input wire logic fetch_done,
    input wire logic move_done,
    input wire logic ale,
    input wire logic addr_data_port_oe,
    input wire logic [7:0] high_addr_port,
    input wire logic program_fetch_strobe_n,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n
);
    // ----------------------------------------
    // Shadow of the stretch and move counters
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic [7:0] tcr_r;
    logic [2:0] s_r;
    logic [5:0] n_r;
    logic [5:0] w_r;
    wire ft = ready && fetch_start && !move_start;
    wire mt = ready && move_start;
    wire lo = !rd_strobe_n || !wr_strobe_n;
    wire [5:0] len = {1'b0, s_r, 2'b00} + 6'h9;
    wire [5:0] wid = (s_r == 3'h0) ? 6'h2 : {1'b0, s_r, 2'b00};
    // Counters only judged at strobe and done edges, so no reset needed
    always_ff @(posedge clk) begin
        if (srst)
            tcr_r <= 8'h01;
        else if (sfr.wr && sfr.addr == 8'h8e)
            tcr_r <= sfr.wdata;
        if (mt)
            s_r <= tcr_r[2:0];
        n_r <= mt ? 6'h1 : n_r + 6'h1;
        w_r <= lo ? w_r + 6'h1 : 6'h0;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_fetch_gap: assert property (ft |=> !ready[*3] ##1 ready)
        else $error("fetch did not free the bus after four clocks");
    chk_fetch_pulse: assert property (ft |-> ##3
        !program_fetch_strobe_n[*2] ##1 (program_fetch_strobe_n && fetch_done))
        else $error("fetch strobe pulse wrong");
    chk_addr_phase: assert property (ft |-> ##2
        (ale && high_addr_port == $past(fetch_addr[15:8], 2)))
        else $error("address phase wrong");
    chk_move_len: assert property (move_done |-> n_r == len)
        else $error("data move length wrong");
    chk_strobe_start: assert property ($rose(lo) |->
        n_r == ((s_r == 3'h0) ? 6'h7 : 6'h6))
        else $error("strobe starts in wrong clock");
    chk_strobe_width: assert property ($fell(lo) |-> w_r == wid)
        else $error("strobe width wrong");
    chk_program_fetch_strobe_n_idle: assert property (lo |-> program_fetch_strobe_n)
        else $error("fetch strobe low during data move");
    chk_port_turn: assert property ((rd_strobe_n || !addr_data_port_oe) &&
        (wr_strobe_n || addr_data_port_oe))
        else $error("port drive wrong during strobe");
    chk_reset_quiet: assert property ($past(srst) |->
        (program_fetch_strobe_n && ready && !lo))
        else $error("bus not idle after reset");
    chk_sfr_read: assert property (sfr.rd |=> sfr_rvalid &&
        sfr_rdata == (($past(sfr.addr) == 8'h8e) ? $past(tcr_r) : 8'h00))
        else $error("register read wrong");
    cover property (ft);
    cover property ($fell(wr_strobe_n));
    cover property ($fell(rd_strobe_n));
endmodule

bind sxb_bus sxb_bus_sva sxb_bus_sva_i (.*);

// ---- bench/sxb_mem.sv ----
// External memory model on the multiplexed port.
// Assumes the low address is latched while ale is high.
`timescale 1ns/1ps
module sxb_mem
    import sxb_pkg::*;
(
    input wire logic clk,
    input wire logic ale,
    input wire logic [7:0] addr_data_port_out,
    input wire logic program_fetch_strobe_n,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic [2:0] lag,
    output logic [7:0] addr_data_port_in
);
    // ----------------------------------------
    // Storage and answer
    // ----------------------------------------
    logic [7:0] mem [256];
    logic [7:0] a_r;
    logic [7:0] q_r;
    logic [2:0] c_r;
    wire idle = rd_strobe_n && program_fetch_strobe_n;
    initial begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5a;
    end
    // Slow part: data only appears lag clocks into the strobe
    always @(posedge clk) begin
        if (ale)
            a_r <= addr_data_port_out;
        if (!wr_strobe_n)
            mem[a_r] <= addr_data_port_out;
        c_r <= idle ? 3'h0 : c_r + {2'b00, c_r != 3'h7};
        // Fetches answer at once; only data reads feel the lag
        if (!idle && (c_r >= lag || !program_fetch_strobe_n))
            q_r <= mem[a_r];
        else
            q_r <= ~q_r;
    end
    assign addr_data_port_in = q_r;
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the external data bus engine.
// Assumes sxb_bus with the sxb_mem model on its port.
`timescale 1ns/1ps
module testbench
    import sxb_pkg::*;
;
    logic clk, srst, fetch_start, move_start, ready, fetch_done, move_done;
    logic sfr_rvalid, ale, addr_data_port_oe, program_fetch_strobe_n;
    logic rd_strobe_n, wr_strobe_n;
    logic [15:0] fetch_addr;
    logic [7:0] sfr_rdata, fetch_data, move_rdata, addr_data_port_out;
    logic [7:0] addr_data_port_in, high_addr_port;
    logic [2:0] lag;
    logic sv;
    logic [7:0] sq;
    sxb_sfr_req_t sfr;
    sxb_move_req_t move_req;
    int fail_count, samples_checked;
    sxb_bus sxb_bus_i (.*);
    sxb_mem sxb_mem_i (.*);
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task tk;
        @(posedge clk);
        #1;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Answer is taken in its one valid cycle, then a quiet clock passes
    task sfr_op(input logic w, input logic [7:0] a, input logic [7:0] d,
                output logic v, output logic [7:0] q);
        sfr = '{w, !w, a, d};
        tk;
        v = sfr_rvalid;
        q = sfr_rdata;
        sfr = '0;
        tk;
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic v;
        logic [7:0] q;
        sfr_op(1'b0, a, 8'h00, v, q);
        chk({7'h0, v}, 8'h01);
        chk(q, e);
    endtask
    task fetch(input logic [15:0] a);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 60) begin
            tk;
            n++;
        end
        fetch_addr = a;
        fetch_start = 1;
        tk;
        fetch_start = 0;
        n = 1;
        while (fetch_done !== 1'b1 && n < 60) begin
            tk;
            n++;
        end
        chk(8'(n), 8'h05);
        chk(fetch_data, a[7:0] ^ 8'h5a);
    endtask
    task move(input logic w, input logic [2:0] s, input logic [7:0] d);
        int n, m;
        n = 0;
        m = 0;
        while (ready !== 1'b1 && n < 60) begin
            tk;
            n++;
        end
        move_req = '{w, {13'h0800, s}, d};
        move_start = 1;
        tk;
        move_start = 0;
        n = 1;
        while (move_done !== 1'b1 && n < 60) begin
            if (!rd_strobe_n || !wr_strobe_n)
                m++;
            tk;
            n++;
        end
        chk(8'(n), 8'(4 * s + 9));
        chk(8'(m), (s == 3'h0) ? 8'h02 : 8'(4 * s));
        chk(high_addr_port, 8'h40);
        if (!w)
            chk(move_rdata, d);
    endtask
    task wrap_up;
        $display("checked %0d, failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and sequence
    // ----------------------------------------
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #60000;
        fail_count++;
        wrap_up;
    end
    initial begin
        {srst, fetch_start, move_start, fetch_addr, lag} = {1'b1, 21'h0};
        {sfr, move_req, fail_count, samples_checked} = '0;
        repeat (6) @(posedge clk);
        #1 srst = 0;
        rd_chk(8'h8e, 8'h01);
        move(1'b1, 3'h1, 8'h3c);
        move(1'b0, 3'h1, 8'h3c);
        sfr_op(1'b1, 8'h8d, 8'hff, sv, sq);
        rd_chk(8'h8e, 8'h01);
        rd_chk(8'h90, 8'h00);
        fetch(16'h1234);
        for (int s = 0; s < 8; s++) begin
            sfr_op(1'b1, 8'h8e, {5'h15, s[2:0]}, sv, sq);
            rd_chk(8'h8e, {5'h15, s[2:0]});
            lag = (s == 0) ? 3'h0 : 3'h2;
            move(1'b1, s[2:0], {5'h06, s[2:0]});
            move(1'b0, s[2:0], {5'h06, s[2:0]});
            fetch({13'h0410, s[2:0]});
        end
        wrap_up;
    end
endmodule

// ---- rtl/sxb_bus.sv ----
// Stretchable external data bus engine: program fetches and external
// data moves on a multiplexed address/data port plus a high-address port.
// Assumes clk is the oscillator clock and requests are one-cycle pulses.
//
// Summary of operation
// RULE1 - A machine cycle lasts four oscillator clocks.
// RULE2 - Low address and data share one port; high address has its own.
// RULE3 - Program fetches run at a fixed rate, one machine cycle each.
// RULE4 - Three low bits of the timing register at 8Eh pick stretch 0-7.
// RULE5 - Stretch zero gives a data move of two machine cycles.
// RULE6 - A data move lasts stretch plus two machine cycles; nine at seven.
// RULE7 - Strobe is two clocks at stretch zero, else four per stretch step.
// RULE8 - After reset the stretch is one, a three machine cycle move.
// RULE9 - Stretch one to seven widens strobe and surrounding bus timing.
// RULE10 - Software may rewrite stretch anytime; later moves use it.
// RULE11 - Stretch affects data moves only, never program fetch timing.
// RULE12 - Fetch strobe stays high during data moves and during reset.
// RULE13 - Fetch strobe pulses low each fetch, repeating every four clocks.
// RULE14 - External memory answers within the strobe width selected.
// RULE15 - Register writes change only the stretch field for this block.
`timescale 1ns/1ps

`include "sxb_map.svh"

module sxb_bus
    import sxb_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire sxb_sfr_req_t sfr,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    input wire logic fetch_start,
    input wire logic [15:0] fetch_addr,
    input wire logic move_start,
    input wire sxb_move_req_t move_req,
    output logic ready,
    output logic fetch_done,
    output logic [7:0] fetch_data,
    output logic move_done,
    output logic [7:0] move_rdata,
    output logic ale,
    output logic [7:0] addr_data_port_out,
    output logic addr_data_port_oe,
    input wire logic [7:0] addr_data_port_in,
    output logic [7:0] high_addr_port,
    output logic program_fetch_strobe_n,
    output logic rd_strobe_n,
    output logic wr_strobe_n
);

    // ----------------------------------------
    // Timing functions
    // ----------------------------------------
    function automatic logic [5:0] move_last(input logic [2:0] s);
        move_last = 6'(({3'h0, s} + `SXB_MOVE_BASE_MC) * `SXB_CLKS_PER_MC
            - 6'h1); // RULE1 RULE5 RULE6
    endfunction

    function automatic logic [5:0] strb_off(input logic [2:0] s);
        strb_off = (s == 3'h0) ? `SXB_STRB0_OFF : `SXB_STRB_OFF;
    endfunction

    function automatic logic [5:0] strb_clks(input logic [2:0] s);
        strb_clks = (s == 3'h0) ? `SXB_STRB0_CLKS : {1'b0, s, 2'b00}; // RULE7
    endfunction

    // ----------------------------------------
    // Timing register
    // ----------------------------------------
    logic [2:0] stretch;

    sxb_timing_reg u_reg (
        .clk(clk),
        .srst(srst),
        .sfr(sfr),
        .rdata(sfr_rdata),
        .rvalid(sfr_rvalid),
        .stretch(stretch)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    sxb_state_t state_r;
    sxb_state_t state_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [5:0] last_r;
    logic [5:0] last_nxt;
    logic [2:0] st_r;
    logic [2:0] st_nxt;
    logic wr_r;
    logic wr_nxt;
    logic [15:0] addr_r;
    logic [15:0] addr_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;

    wire at_last = (state_r != SXB_IDLE) && (cnt_r == last_r);
    wire free = (state_r == SXB_IDLE) || at_last;
    // A data move wins when both arrive together
    wire take_move = free && move_start;
    wire take_fetch = free && fetch_start && !move_start;

    // Stretch is sampled at the start, so a rewrite never upsets a move
    assign state_nxt = take_move ? SXB_MOVE :
                       take_fetch ? SXB_FETCH :
                       at_last ? SXB_IDLE : state_r;
    assign cnt_nxt = (take_move || take_fetch || at_last) ? 6'h0 :
                     (state_r == SXB_IDLE) ? 6'h0 : 6'(cnt_r + 6'h1);
    assign st_nxt = take_move ? stretch : st_r; // RULE10 RULE11
    assign last_nxt = take_move ? move_last(stretch) :
                      take_fetch ? `SXB_FETCH_LAST : last_r; // RULE3 RULE11
    assign wr_nxt = take_move ? move_req.wr : wr_r;
    assign addr_nxt = take_move ? move_req.addr :
                      take_fetch ? fetch_addr : addr_r;
    assign wdata_nxt = take_move ? move_req.wdata : wdata_r;

    wire free_nxt = (state_nxt == SXB_IDLE) || (cnt_nxt == last_nxt);

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= SXB_IDLE;
            cnt_r <= 6'h0;
            last_r <= 6'h0;
            st_r <= 3'h0;
            wr_r <= 1'b0;
            addr_r <= 16'h0000;
            wdata_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            last_r <= last_nxt;
            st_r <= st_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // ----------------------------------------
    // Pin shaping, one clock behind the count
    // ----------------------------------------
    wire in_fetch = (state_r == SXB_FETCH);
    wire in_move = (state_r == SXB_MOVE);
    wire [5:0] s_off = strb_off(st_r);
    wire [5:0] s_end = 6'(s_off + strb_clks(st_r));
    wire s_win = in_move && (cnt_r >= s_off) && (cnt_r < s_end); // RULE9
    wire [5:0] f_end = 6'(`SXB_FETCH_STRB_OFF + `SXB_FETCH_STRB_CLKS);
    wire f_win = in_fetch && (cnt_r >= `SXB_FETCH_STRB_OFF) &&
                 (cnt_r < f_end); // RULE13
    wire addr_phase = (in_fetch || in_move) && (cnt_r == 6'h0);
    // Write data stays one clock past the strobe for hold time
    wire data_phase = in_move && wr_r && (cnt_r != 6'h0) &&
                      (cnt_r <= s_end);
    // Sampled on the edge that releases the strobe
    wire move_sample = in_move && !wr_r && (cnt_r == s_end); // RULE14
    wire fetch_sample = in_fetch && (cnt_r == f_end); // RULE14
    wire [7:0] port_nxt = addr_phase ? addr_r[7:0] : wdata_r;

    logic ale_r;
    logic [7:0] port_r;
    logic oe_r;
    logic [7:0] hi_r;
    logic program_fetch_strobe_n_n_r;
    logic rd_n_r;
    logic wr_n_r;
    logic ready_r;
    logic fdone_r;
    logic mdone_r;
    logic [7:0] fdata_r;
    logic [7:0] mdata_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            ale_r <= 1'b0;
            port_r <= 8'h00;
            oe_r <= 1'b0;
            hi_r <= 8'h00;
            program_fetch_strobe_n_n_r <= 1'b1; // RULE12
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
        end else begin
            ale_r <= addr_phase;
            port_r <= port_nxt; // RULE2
            oe_r <= addr_phase || data_phase;
            hi_r <= addr_r[15:8]; // RULE2
            program_fetch_strobe_n_n_r <= !f_win; // RULE12 RULE13
            rd_n_r <= !(s_win && !wr_r); // RULE7 RULE9
            wr_n_r <= !(s_win && wr_r); // RULE7 RULE9
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ready_r <= 1'b1;
            fdone_r <= 1'b0;
            mdone_r <= 1'b0;
            fdata_r <= 8'h00;
            mdata_r <= 8'h00;
        end else begin
            ready_r <= free_nxt;
            fdone_r <= in_fetch && at_last; // RULE3
            mdone_r <= in_move && at_last; // RULE6
            if (fetch_sample) begin
                fdata_r <= addr_data_port_in;
            end
            if (move_sample) begin
                mdata_r <= addr_data_port_in;
            end
        end
    end

    assign ale = ale_r;
    assign addr_data_port_out = port_r;
    assign addr_data_port_oe = oe_r;
    assign high_addr_port = hi_r;
    assign program_fetch_strobe_n = program_fetch_strobe_n_n_r;
    assign rd_strobe_n = rd_n_r;
    assign wr_strobe_n = wr_n_r;
    assign ready = ready_r;
    assign fetch_done = fdone_r;
    assign fetch_data = fdata_r;
    assign move_done = mdone_r;
    assign move_rdata = mdata_r;

endmodule

// ---- rtl/sxb_map.svh ----
// Constants of the stretchable external data bus: register offset,
// field positions, reset value and clock counts.
// Assumes one clk edge equals one oscillator clock.
`ifndef SXB_MAP_SVH
`define SXB_MAP_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define SXB_TIMING_ADDR 8'h8e
`define SXB_TIMING_RST 8'h01
`define SXB_STRETCH_MSB 2
`define SXB_STRETCH_LSB 0

// ----------------------------------------
// Timing counts, in oscillator clocks except the move base in machine cycles
// ----------------------------------------
`define SXB_CLKS_PER_MC 6'h4
`define SXB_MOVE_BASE_MC 6'h2
`define SXB_FETCH_LAST 6'h3
`define SXB_FETCH_STRB_OFF 6'h1
`define SXB_FETCH_STRB_CLKS 6'h2
`define SXB_STRB0_OFF 6'h5
`define SXB_STRB0_CLKS 6'h2
`define SXB_STRB_OFF 6'h4

`endif

// ---- rtl/sxb_pkg.sv ----
// Types shared by the stretchable external data bus files.
// Assumes nothing beyond a SystemVerilog compiler.
package sxb_pkg;

    // ----------------------------------------
    // Bus engine states
    // ----------------------------------------
    typedef enum logic [1:0] {
        SXB_IDLE = 2'b00,
        SXB_FETCH = 2'b01,
        SXB_MOVE = 2'b10
    } sxb_state_t;

    // ----------------------------------------
    // Request carriers
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } sxb_move_req_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sxb_sfr_req_t;

endpackage

// ---- rtl/sxb_timing_reg.sv ----
// Bus timing control register on the special-function register port.
// Assumes one access per cycle from the core; read data one cycle later.
`timescale 1ns/1ps

`include "sxb_map.svh"

module sxb_timing_reg
    import sxb_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire sxb_sfr_req_t sfr,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic [2:0] stretch
);

    logic [7:0] value_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    wire hit = (sfr.addr == `SXB_TIMING_ADDR);
    wire wr_hit = sfr.wr && hit;

    // Upper bits are stored for their owners; only the field is used here
    always_ff @(posedge clk) begin
        if (srst) begin
            value_r <= `SXB_TIMING_RST; // RULE8
        end else if (wr_hit) begin
            value_r <= sfr.wdata; // RULE10
        end
    end

    // Unmapped reads answer zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= sfr.rd;
            rdata_r <= (sfr.rd && hit) ? value_r : 8'h00;
        end
    end

    assign rdata = rdata_r;
    assign rvalid = rvalid_r;
    assign stretch = value_r[`SXB_STRETCH_MSB:`SXB_STRETCH_LSB]; // RULE4 RULE15

endmodule
